// [verilog/period_match_timer_8bit.sv]
// Top module of the 8-bit period match timer with prescaler and postscaler.
//
// Operation
// R1: Control bits 6..3 pick 1 to 16 period matches per interrupt flag setting.
// R2: Control bit 2 runs the timer when one, stops it when zero.
// R3: Control bits 1..0 divide the instruction clock: 00 by 1, 01 by 4, 1x by 16.
// R4: Each match advances a 4-bit postscaler; reaching the ratio yields the event.
// R5: The postscaler event sets the match flag, latched until software clears it.
// R6: The match enable bit decides whether the latched flag raises the interrupt.
// R7: The unscaled match pulse goes out as a PWM time base.
// R8: The timer output is offered as a shift clock for the serial port.
// R9: Control bit 7 reads zero and ignores writes.
// R10: Count starts at zero, increments per prescaled tick, returns to zero after match.
// R11: Reset clears the count and sets the period register to all ones.
// R12: Count or control writes and reset clear both scalers; control writes keep count.
// R13: A stopped timer holds count and scalers and makes no match or event.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module period_match_timer_8bit (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic pwm_timebase_o,
  output logic spi_shift_clk_o
);

  // ****************************************************************
  // Prescale ratio decode
  // ****************************************************************
  function automatic logic [3:0] prescale_limit(input logic [1:0] sel);
    logic [3:0] lim;
    lim = period_match_timer_pkg::PRESCALE_LIMIT_DIV16;
    if (sel == period_match_timer_pkg::PRESCALE_DIV1) begin
      lim = period_match_timer_pkg::PRESCALE_LIMIT_DIV1;
    end else if (sel == period_match_timer_pkg::PRESCALE_DIV4) begin
      lim = period_match_timer_pkg::PRESCALE_LIMIT_DIV4;
    end
    return lim;
  endfunction

  // ****************************************************************
  // Bus request decode
  // ****************************************************************
  period_match_timer_pkg::bus_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  wire logic wr_control = req.wr && (req.addr == period_match_timer_pkg::TIMER_CONTROL_OFFSET);
  wire logic wr_count = req.wr && (req.addr == period_match_timer_pkg::COUNT_REGISTER_OFFSET);
  wire logic wr_period = req.wr && (req.addr == period_match_timer_pkg::PERIOD_REGISTER_OFFSET);
  wire logic wr_irq_req = req.wr && (req.addr == period_match_timer_pkg::PERIPH_IRQ_REQUEST_OFFSET);
  wire logic wr_irq_en = req.wr && (req.addr == period_match_timer_pkg::PERIPH_IRQ_ENABLE_OFFSET);

  // ****************************************************************
  // State
  // ****************************************************************
  period_match_timer_pkg::timer_control_t control_reg;
  logic [7:0] count_reg;
  logic [7:0] period_reg;
  logic [3:0] prescale_reg;
  logic [3:0] postscale_reg;
  logic [1:0] instr_div_reg;
  logic match_irq_flag_reg;
  logic match_irq_enable_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic pwm_reg;
  logic spi_clk_reg;

  // ****************************************************************
  // Timing chain
  // ****************************************************************
  wire logic instr_tick = (instr_div_reg == period_match_timer_pkg::INSTR_DIV_LAST);
  wire logic run = control_reg.timer_run_bit;  // [R2]
  wire logic [3:0] ps_limit = prescale_limit(control_reg.prescale_select);  // [R3]
  wire logic prescaled_tick = run && instr_tick && (prescale_reg == ps_limit);  // [R3] [R13]
  wire logic period_match = prescaled_tick && (count_reg == period_reg);  // [R10]
  wire logic post_event = period_match && (postscale_reg == control_reg.postscale_select);  // [R1] [R4]
  wire logic scaler_clear = wr_count || wr_control;  // [R12]

  logic [3:0] prescale_next;
  logic [3:0] postscale_next;
  logic [7:0] count_next;
  logic match_irq_flag_next;

  // The prescaler only counts while running; the control write that stops or restarts the timer clears its phase.
  always_comb begin
    prescale_next = prescale_reg;
    if (scaler_clear) begin
      prescale_next = period_match_timer_pkg::SCALER_RESET;  // [R12]
    end else if (run && instr_tick) begin
      prescale_next = (prescale_reg == ps_limit) ? period_match_timer_pkg::SCALER_RESET : 4'(prescale_reg + 4'h1);
    end
  end

  always_comb begin
    postscale_next = postscale_reg;
    if (scaler_clear) begin
      postscale_next = period_match_timer_pkg::SCALER_RESET;  // [R12]
    end else if (post_event) begin
      postscale_next = period_match_timer_pkg::SCALER_RESET;  // [R4]
    end else if (period_match) begin
      postscale_next = 4'(postscale_reg + 4'h1);  // [R4]
    end
  end

  // A count write wins over the match reset, so software can preload in mid-period.
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = req.wdata;
    end else if (period_match) begin
      count_next = period_match_timer_pkg::COUNT_RESET;  // [R10]
    end else if (prescaled_tick) begin
      count_next = 8'(count_reg + 8'h01);  // [R10]
    end
  end

  // A hardware event in the same cycle as a software clear wins, so no match is lost.
  always_comb begin
    match_irq_flag_next = match_irq_flag_reg;
    if (wr_irq_req) begin
      match_irq_flag_next = req.wdata[period_match_timer_pkg::MATCH_IRQ_BIT];
    end
    if (post_event) begin
      match_irq_flag_next = 1'b1;  // [R5]
    end
  end

  // ****************************************************************
  // Read decode
  // ****************************************************************
  // Unmapped addresses read zero, and writes to them are dropped.
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        period_match_timer_pkg::TIMER_CONTROL_OFFSET: rdata_next = {1'b0, control_reg};  // [R9]
        period_match_timer_pkg::COUNT_REGISTER_OFFSET: rdata_next = count_reg;
        period_match_timer_pkg::PERIOD_REGISTER_OFFSET: rdata_next = period_reg;
        period_match_timer_pkg::PERIPH_IRQ_REQUEST_OFFSET:
          rdata_next = 8'({match_irq_flag_reg, 1'b0});
        period_match_timer_pkg::PERIPH_IRQ_ENABLE_OFFSET:
          rdata_next = 8'({match_irq_enable_reg, 1'b0});
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Software-owned configuration; only bus writes change it.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      control_reg <= period_match_timer_pkg::TIMER_CONTROL_RESET;
      period_reg <= period_match_timer_pkg::PERIOD_RESET;  // [R11]
      match_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_control) begin
        control_reg <= req.wdata[6:0];  // [R9]
      end
      if (wr_period) begin
        period_reg <= req.wdata;
      end
      if (wr_irq_en) begin
        match_irq_enable_reg <= req.wdata[period_match_timer_pkg::MATCH_IRQ_BIT];  // [R6]
      end
    end
  end

  // The instruction divider free-runs, so bus writes never shift the tick phase.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      instr_div_reg <= period_match_timer_pkg::INSTR_DIV_RESET;
    end else begin
      instr_div_reg <= 2'(instr_div_reg + 2'h1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      count_reg <= period_match_timer_pkg::COUNT_RESET;  // [R11]
      prescale_reg <= period_match_timer_pkg::SCALER_RESET;  // [R12]
      postscale_reg <= period_match_timer_pkg::SCALER_RESET;  // [R12]
      match_irq_flag_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      prescale_reg <= prescale_next;
      postscale_reg <= postscale_next;
      match_irq_flag_reg <= match_irq_flag_next;
    end
  end

  // Outputs are registered so downstream units see clean, glitch-free levels.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      pwm_reg <= 1'b0;
      spi_clk_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      irq_reg <= match_irq_flag_next && match_irq_enable_reg;  // [R6]
      pwm_reg <= period_match;  // [R7]
      // The shift clock toggles once per match, so it runs at half the match rate.
      if (period_match) begin
        spi_clk_reg <= ~spi_clk_reg;  // [R8]
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign pwm_timebase_o = pwm_reg;
  assign spi_shift_clk_o = spi_clk_reg;

endmodule // period_match_timer_8bit

// [verilog/period_match_timer_pkg.sv]
// Package of constants and types for the 8-bit period match timer.
package period_match_timer_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 3;
  localparam logic [2:0] TIMER_CONTROL_OFFSET = 3'h0;
  localparam logic [2:0] COUNT_REGISTER_OFFSET = 3'h1;
  localparam logic [2:0] PERIOD_REGISTER_OFFSET = 3'h2;
  localparam logic [2:0] PERIPH_IRQ_REQUEST_OFFSET = 3'h3;
  localparam logic [2:0] PERIPH_IRQ_ENABLE_OFFSET = 3'h4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POSTSCALE_LSB = 3;
  localparam int RUN_BIT = 2;
  localparam int PRESCALE_LSB = 0;
  localparam int MATCH_IRQ_BIT = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [6:0] TIMER_CONTROL_RESET = 7'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [3:0] SCALER_RESET = 4'h0;
  localparam logic [1:0] INSTR_DIV_RESET = 2'h0;

  // ****************************************************************
  // Prescale codes and clocking
  // ****************************************************************
  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
  localparam logic [3:0] PRESCALE_LIMIT_DIV1 = 4'h0;
  localparam logic [3:0] PRESCALE_LIMIT_DIV4 = 4'h3;
  localparam logic [3:0] PRESCALE_LIMIT_DIV16 = 4'hF;
  // The instruction clock is the oscillator clock divided by four.
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(OSC_PER_INSTR - 1);

  // Control register fields, bit 7 is absent.
  typedef struct packed {
    logic [3:0] postscale_select;
    logic timer_run_bit;
    logic [1:0] prescale_select;
  } timer_control_t;

  // One register bus request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

// [test/period_match_timer_chk.sv]
// Port checker of the 8-bit period match timer.
`timescale 1ns/1ps
module period_match_timer_chk (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire logic pwm_timebase_o,
  input wire logic spi_shift_clk_o
);
  // ********
  // Checks
  // ********
  // The interrupt lags the enable by a cycle, so its changes are judged against writes up to two cycles back.
  wire irq_wr = wr_i && (addr_i == 3'h3 || addr_i == 3'h4);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  ctrl_msb_a: assert property ($past(rd_i && addr_i == 3'h0) |-> !rdata_o[7])
    else $error("control bit 7 read as one");
  pwm_pulse_a: assert property (pwm_timebase_o |=> !pwm_timebase_o [*3])
    else $error("time base pulses too close");
  spi_follow_a: assert property ($changed(spi_shift_clk_o) == pwm_timebase_o)
    else $error("shift clock not tied to match");
  irq_hold_a: assert property (irq_o && !irq_wr && !$past(irq_wr) |=> irq_o)
    else $error("interrupt dropped by itself");
  irq_cause_a: assert property ($rose(irq_o) |-> pwm_timebase_o || $past(pwm_timebase_o) ||
    $past(irq_wr) || $past(irq_wr, 2)) else $error("interrupt without cause");
  irq_clear_a: assert property (wr_i && addr_i == 3'h3 && !wdata_i[1] |=> (!irq_o || pwm_timebase_o))
    else $error("flag clear ignored");
  irq_disable_a: assert property (wr_i && addr_i == 3'h4 && !wdata_i[1] |=> ##1 !irq_o)
    else $error("disabled interrupt raised");
  stop_quiet_a: assert property (wr_i && addr_i == 3'h0 && !wdata_i[2] |=> ##1 !pwm_timebase_o [*8])
    else $error("match while stopped");
  cover property (pwm_timebase_o);
  cover property ($rose(irq_o));
  cover property ($changed(spi_shift_clk_o));
endmodule // period_match_timer_chk

// [test/period_match_timer_8bit_tb.sv]
// Self-checking testbench of the 8-bit period match timer.
`timescale 1ns/1ps
bind period_match_timer_8bit period_match_timer_chk i_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pwm_timebase_o(pwm_timebase_o),
  .spi_shift_clk_o(spi_shift_clk_o));
module period_match_timer_8bit_tb;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o;
  logic pwm_timebase_o;
  logic spi_shift_clk_o;
  int n_errors = 0;
  int check_count = 0;
  int n;
  int c;
  logic sp;
  always #12.5 mclk_i = ~mclk_i;
  period_match_timer_8bit i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pwm_timebase_o(pwm_timebase_o), .spi_shift_clk_o(spi_shift_clk_o));
  // ********
  // Tasks
  // ********
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(what, exp, rdata_o);
    @(posedge mclk_i);
  endtask
  // Gaps are timed pulse to pulse so the phase of the free-running instruction divider does not matter.
  task automatic gap(output int g);
    g = 0;
    do begin
      @(negedge mclk_i);
      g++;
    end while (pwm_timebase_o !== 1'b1 && g < 900);
    @(posedge mclk_i);
  endtask
  task automatic see_irq(input logic e);
    @(negedge mclk_i);
    chk("irq", {7'h00, e}, {7'h00, irq_o});
    @(posedge mclk_i);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(3'h0, 8'h00, "control");
    rd(3'h1, 8'h00, "count");
    rd(3'h2, 8'hFF, "period");
    rd(3'h3, 8'h00, "request");
    wr(3'h0, 8'hFF);
    rd(3'h0, 8'h7F, "control");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h07);
    wr(3'h0, 8'h78);
    repeat (40) @(posedge mclk_i);
    rd(3'h1, 8'h07, "count");
    rd(3'h0, 8'h78, "control");
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00, "unmapped");
    wr(3'h2, 8'h02);
    wr(3'h1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(3'h0, 8'(4 + k));
      gap(n);
      sp = spi_shift_clk_o;
      gap(n);
      chk("match interval", k == 0 ? 8'h0C : (k == 1 ? 8'h30 : 8'hC0), 8'(n));
      chk("shift clock", {7'h00, ~sp}, {7'h00, spi_shift_clk_o});
    end
    for (int s = 0; s < 16; s++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h4, 8'h02);
      wr(3'h0, 8'(s * 8 + 4));
      n = 0;
      c = 0;
      do begin
        @(negedge mclk_i);
        n += int'(pwm_timebase_o === 1'b1);
        c++;
      end while (irq_o !== 1'b1 && c < 400);
      @(posedge mclk_i);
      chk("matches per flag", 8'(s + 1), 8'(n));
    end
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h04);
    repeat (40) @(posedge mclk_i);
    wr(3'h0, 8'h00);
    rd(3'h3, 8'h02, "request");
    see_irq(1'b0);
    wr(3'h4, 8'h02);
    see_irq(1'b1);
    wr(3'h3, 8'h00);
    see_irq(1'b0);
    report_and_stop();
  end
endmodule // period_match_timer_8bit_tb
